// ==== src/link_test_pattern_gen.sv ====
`timescale 1ns/1ns
module link_test_pattern_gen
    import link_test_pkg::*;
(
    input  wire logic                  sys_clk_i,
    input  wire logic                  resetn_i,
    input  wire logic [2:0]            test_mode_i,
    input  wire logic [4:0]            link_format_select_i,
    input  wire logic [1:0]            part_variant_i,
    input  wire logic                  enc_64b66b_i,
    input  wire logic [LANE_COUNT-1:0] lane_enable_i,
    input  wire logic                  sync_req_n_i,
    input  wire logic [LANE_BUS_W-1:0] sample_data_i,
    input  wire logic                  sample_valid_i,
    output logic                       sample_ready_o,
    output logic [LANE_BUS_W-1:0]      lane_data_o,
    output logic [LANE_COUNT-1:0]      lane_ctrl_o,
    output logic [LANE_COUNT-1:0]      lane_active_o,
    output logic                       lane_valid_o,
    input  wire logic                  lane_ready_i,
    output logic                       test_active_o
);

    // =====================================================================
    // transport pattern octet for one lane at one position
    function automatic logic [7:0] transport_octet(input logic [2:0] lane,
                                                   input logic [6:0] pos);
        logic [11:0] w1;
        logic [11:0] w2;
        w1 = {4'hf - {1'b0, lane}, {1'b0, lane}, 4'h1};
        w2 = {4'hf - {1'b0, lane}, {1'b0, lane}, 4'h2};
        case (pos[1:0])
            2'b00:   transport_octet = w1[11:4];
            2'b01:   transport_octet = {w1[3:0], w2[11:8]};
            default: transport_octet = w2[7:0];
        endcase
    endfunction : transport_octet

    // =====================================================================
    // state
    test_mode_t             mode_prev_reg;
    ila_state_t             ila_state_reg;
    ila_state_t             ila_state_next;
    logic [6:0]             pos_reg;
    logic [6:0]             pos_next;
    logic [LANE_BUS_W-1:0]  data_reg;
    logic [LANE_BUS_W-1:0]  data_next;
    logic [LANE_COUNT-1:0]  ctrl_reg;
    logic [LANE_COUNT-1:0]  ctrl_next;
    logic [LANE_COUNT-1:0]  active_reg;
    logic                   valid_reg;
    logic                   valid_next;
    logic                   test_reg;

    logic [LANE_BUS_W-1:0]  fifo_data;
    logic                   fifo_valid;
    logic                   fifo_ready;

    // =====================================================================
    // sample buffer between converter and link
    link_test_fifo #(
        .WIDTH (LANE_BUS_W),
        .DEPTH (FIFO_DEPTH)
    ) u_sample_fifo (
        .sys_clk_i   (sys_clk_i),
        .resetn_i    (resetn_i),
        .in_data_i   (sample_data_i),
        .in_valid_i  (sample_valid_i),
        .in_ready_o  (sample_ready_o),
        .out_data_o  (fifo_data),
        .out_valid_o (fifo_valid),
        .out_ready_i (fifo_ready)
    );

    // =====================================================================
    // mode qualification: 8b/10b-only modes fall back to samples in 64b/66b
    test_mode_t req_mode;
    test_mode_t eff_mode;
    logic       fmt_transport;
    logic       only_8b10b;
    logic       advance;
    logic       mode_changed;

    assign req_mode      = test_mode_t'(test_mode_i);
    assign fmt_transport = (link_format_select_i == FORMAT_14) ||
                           (link_format_select_i == FORMAT_15);
    assign only_8b10b    = (req_mode == MODE_K285) || (req_mode == MODE_ILA_REP) ||
                           (req_mode == MODE_RPAT);
    assign eff_mode      = (only_8b10b && enc_64b66b_i) ? MODE_NORMAL :
                           (req_mode == MODE_TRANSPORT && !fmt_transport) ? MODE_NORMAL :
                           (req_mode > MODE_RPAT) ? MODE_NORMAL : req_mode;
    assign advance       = !valid_reg || lane_ready_i;
    assign mode_changed  = (eff_mode != mode_prev_reg);

    // =====================================================================
    // lanes present for the transport pattern
    logic [LANE_COUNT-1:0] present_mask;
    logic                  upper_pair;
    logic                  upper_quad;

    assign upper_pair = (part_variant_i == PART_DUAL) || (part_variant_i == PART_QUAD);
    assign upper_quad = (link_format_select_i == FORMAT_14) ?
                        (part_variant_i == PART_QUAD) :
                        (part_variant_i == PART_DUAL);
    assign present_mask = {{4{upper_quad}},
                           {2{upper_pair || (link_format_select_i == FORMAT_15)}},
                           2'b11};

    // =====================================================================
    // position counter: wraps per pattern, restarts on mode change, or on sync in repeated ila mode
    logic [6:0] pos_last;
    logic [6:0] pos_cur;
    logic       ila_hold;
    assign pos_last = (eff_mode == MODE_TRANSPORT) ? TRANSPORT_LAST :
                      (eff_mode == MODE_RPAT)      ? RPAT_LAST : ILA_LAST;
    // a new mode sends position 0 in the very first word, not one word late
    assign pos_cur  = mode_changed ? POS_RESET : pos_reg;
    // held at 0 through cgs so the sequence opens with its first octet
    assign ila_hold = (eff_mode == MODE_ILA_REP) &&
                      ((ila_state_reg == ILA_CGS) || (ila_state_next == ILA_CGS));

    always_comb begin
        pos_next = pos_cur;
        if (ila_hold) begin
            pos_next = POS_RESET;
        end else if (advance && eff_mode != MODE_NORMAL) begin
            pos_next = (pos_cur == pos_last) ? POS_RESET : pos_cur + 7'h01;
        end
    end

    // =====================================================================
    // repeated alignment state machine
    always_comb begin
        ila_state_next = ila_state_reg;
        case (ila_state_reg)
            ILA_CGS: begin
                if (eff_mode == MODE_ILA_REP && sync_req_n_i && advance) begin
                    ila_state_next = ILA_SEQ;
                end
            end
            ILA_SEQ: begin
                if (eff_mode != MODE_ILA_REP || !sync_req_n_i) begin
                    ila_state_next = ILA_CGS;
                end
            end
            default: ila_state_next = ILA_CGS;
        endcase
    end

    // =====================================================================
    // character shared by all lanes for stream modes
    logic [7:0] ila_octet;
    logic       ila_k;
    logic [7:0] common_octet;
    logic       common_k;
    logic       mf_first;
    logic       mf_last;
    logic       mf_marker;

    assign mf_first  = (pos_cur[4:0] == 5'h00);
    assign mf_last   = (pos_cur[4:0] == ILA_MF_LAST);
    assign mf_marker = (pos_cur[6:5] == 2'b01) && (pos_cur[4:0] == 5'h01);
    assign ila_k     = (ila_state_reg == ILA_CGS) || mf_first || mf_last || mf_marker;
    assign ila_octet = (ila_state_reg == ILA_CGS) ? CHAR_K285 :
                       mf_first  ? CHAR_K280 :
                       mf_last   ? CHAR_K283 :
                       mf_marker ? CHAR_K284 : {1'b0, pos_cur};

    always_comb begin
        common_octet = 8'h00;
        common_k     = 1'b0;
        case (eff_mode)
            MODE_D215: common_octet = CHAR_D215;
            MODE_K285: begin
                common_octet = CHAR_K285;
                common_k     = 1'b1;
            end
            MODE_ILA_REP: begin
                common_octet = ila_octet;
                common_k     = ila_k;
            end
            // octets chosen so encoder pairs match references
            MODE_RPAT: common_octet = rpat_octet(pos_cur);
            default:   common_octet = 8'h00;
        endcase
    end

    // =====================================================================
    // per-lane selection of the next output octet
    logic [LANE_COUNT-1:0] lane_on;
    assign lane_on = (eff_mode == MODE_TRANSPORT) ? (lane_enable_i & present_mask) :
                     lane_enable_i;

    for (genvar ln = 0; ln < LANE_COUNT; ln++) begin : g_lane
        logic [7:0] tp_octet;
        logic [7:0] pick;
        assign tp_octet = transport_octet(3'(ln), pos_cur);
        assign pick = (eff_mode == MODE_TRANSPORT) ? tp_octet :
                      (eff_mode == MODE_NORMAL) ? fifo_data[ln*OCTET_W +: OCTET_W] :
                      common_octet;
        assign data_next[ln*OCTET_W +: OCTET_W] = lane_on[ln] ? pick : 8'h00;
        assign ctrl_next[ln] = lane_on[ln] && (eff_mode != MODE_NORMAL) && common_k &&
                               (eff_mode != MODE_TRANSPORT);
    end

    // samples flow only in normal mode
    assign fifo_ready = advance && (eff_mode == MODE_NORMAL);
    assign valid_next = (eff_mode == MODE_NORMAL) ? fifo_valid : 1'b1;

    // =====================================================================
    // output and control registers
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            data_reg      <= '0;
            ctrl_reg      <= '0;
            valid_reg     <= 1'b0;
            active_reg    <= '0;
            test_reg      <= 1'b0;
            pos_reg       <= POS_RESET;
            mode_prev_reg <= MODE_NORMAL;
            ila_state_reg <= ILA_CGS;
        end else begin
            if (advance) begin
                data_reg  <= data_next;
                ctrl_reg  <= ctrl_next;
                valid_reg <= valid_next;
            end
            active_reg    <= lane_on;
            test_reg      <= (eff_mode != MODE_NORMAL);
            pos_reg       <= pos_next;
            mode_prev_reg <= eff_mode;
            ila_state_reg <= ila_state_next;
        end
    end

    assign lane_data_o   = data_reg;
    assign lane_ctrl_o   = ctrl_reg;
    assign lane_valid_o  = valid_reg;
    assign lane_active_o = active_reg;
    assign test_active_o = test_reg;

    // =====================================================================
    // assertions
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);

    logic stable_mode;
    assign stable_mode = !mode_changed;

    a_k285_stream: assert property (
        (eff_mode == MODE_K285) && stable_mode && advance && lane_enable_i[0] |=>
        lane_data_o[7:0] == CHAR_K285 && lane_ctrl_o[0])
        else $error("k28.5 mode did not send k28.5");
    a_d215_stream: assert property (
        (eff_mode == MODE_D215) && advance && lane_enable_i[2] |=>
        lane_data_o[23:16] == CHAR_D215 && !lane_ctrl_o[2])
        else $error("d21.5 mode did not send d21.5");
    a_transport_words: assert property (
        (eff_mode == MODE_TRANSPORT) && stable_mode && advance && pos_reg == 7'h00 &&
        lane_enable_i[1] ##1 lane_ready_i && (eff_mode == MODE_TRANSPORT) |=>
        $past(lane_data_o[15:8]) == 8'he1 && lane_data_o[15:8] == 8'h1e)
        else $error("transport words wrong on lane 1");
    a_fmt14_lanes: assert property (
        (eff_mode == MODE_TRANSPORT) && link_format_select_i == FORMAT_14 &&
        part_variant_i == PART_SINGLE |-> present_mask == 8'h03)
        else $error("format 14 single part lane mask wrong");
    a_fmt15_lanes: assert property (
        (eff_mode == MODE_TRANSPORT) && link_format_select_i == FORMAT_15 &&
        part_variant_i == PART_QUAD |-> present_mask == 8'h0f)
        else $error("format 15 quad part lane mask wrong");
    a_ila_no_data: assert property (
        (eff_mode == MODE_ILA_REP) |-> !fifo_ready && valid_next)
        else $error("samples taken in repeated ila mode");
    a_ila_sync_cgs: assert property (
        (eff_mode == MODE_ILA_REP) && !sync_req_n_i ##1 (eff_mode == MODE_ILA_REP) |->
        ila_state_reg == ILA_CGS && pos_reg == POS_RESET)
        else $error("sync request did not restart cgs");
    a_rpat_cycle: assert property (
        (eff_mode == MODE_RPAT) && stable_mode && advance && pos_reg == RPAT_LAST |=>
        pos_reg == POS_RESET && lane_data_o[7:0] == (lane_enable_i[0] ? 8'h59 : 8'h00))
        else $error("jitter pattern did not wrap after twelve octets");
    a_rpat_first: assert property (
        (eff_mode == MODE_RPAT) && stable_mode && advance && pos_reg == POS_RESET &&
        lane_enable_i[0] |=> lane_data_o[7:0] == 8'hbe)
        else $error("jitter pattern first octet wrong");
    a_normal_return: assert property (
        (eff_mode == MODE_NORMAL) && fifo_valid && advance && lane_enable_i[1] |=>
        lane_valid_o && lane_data_o[15:8] == $past(fifo_data[15:8]) && !test_active_o)
        else $error("samples not restored in normal mode");

    c_k285_run:  cover property ((eff_mode == MODE_K285) [*4]);
    c_rpat_wrap: cover property ((eff_mode == MODE_RPAT) && pos_reg == RPAT_LAST && advance);
    c_ila_seq:   cover property (ila_state_reg == ILA_CGS ##1 ila_state_reg == ILA_SEQ);
    c_fifo_full: cover property (!sample_ready_o);

endmodule : link_test_pattern_gen

// ==== pkg/link_test_pkg.sv ====
package link_test_pkg;

    // =====================================================================
    // lane and buffer geometry
    localparam int LANE_COUNT  = 8;
    localparam int OCTET_W     = 8;
    localparam int LANE_BUS_W  = LANE_COUNT * OCTET_W;
    localparam int FIFO_DEPTH  = 16;

    // =====================================================================
    // test mode selection
    typedef enum logic [2:0] {
        MODE_NORMAL    = 3'b000,
        MODE_TRANSPORT = 3'b001,
        MODE_D215      = 3'b010,
        MODE_K285      = 3'b011,
        MODE_ILA_REP   = 3'b100,
        MODE_RPAT      = 3'b101
    } test_mode_t;

    typedef enum logic [1:0] {
        PART_SINGLE = 2'b00,
        PART_DUAL   = 2'b01,
        PART_QUAD   = 2'b10
    } part_variant_t;

    typedef enum logic {
        ILA_CGS = 1'b0,
        ILA_SEQ = 1'b1
    } ila_state_t;

    // =====================================================================
    // link formats that carry the three-octet transport pattern
    localparam logic [4:0] FORMAT_14 = 5'h0e;
    localparam logic [4:0] FORMAT_15 = 5'h0f;

    // =====================================================================
    // characters fed to the 8b/10b encoder
    localparam logic [7:0] CHAR_D215 = 8'hb5;
    localparam logic [7:0] CHAR_K285 = 8'hbc;
    localparam logic [7:0] CHAR_K280 = 8'h1c;  // multiframe start
    localparam logic [7:0] CHAR_K283 = 8'h7c;  // multiframe end
    localparam logic [7:0] CHAR_K284 = 8'h9c;  // configuration marker

    // =====================================================================
    // pattern lengths and positions
    localparam logic [6:0] TRANSPORT_LAST = 7'h02;
    localparam logic [6:0] RPAT_LAST      = 7'h0b;
    localparam logic [6:0] ILA_LAST       = 7'h7f;  // four multiframes of 32 octets
    localparam logic [4:0] ILA_MF_LAST    = 5'h1f;
    localparam logic [6:0] POS_RESET      = 7'h00;

    // =====================================================================
    // encoded reference pairs of the jitter pattern, checked at the encoder
    localparam logic [19:0] RPAT_ENC_01 = 20'h86ba6;
    localparam logic [19:0] RPAT_ENC_23 = 20'hc6475;
    localparam logic [19:0] RPAT_ENC_45 = 20'hd0e8d;
    localparam logic [19:0] RPAT_ENC_67 = 20'hca8b4;
    localparam logic [19:0] RPAT_ENC_89 = 20'h7949e;
    localparam logic [19:0] RPAT_ENC_AB = 20'haa665;

    // twelve-octet jitter pattern before encoding
    function automatic logic [7:0] rpat_octet(input logic [6:0] pos);
        case (pos[3:0])
            4'h0: rpat_octet = 8'hbe;
            4'h1: rpat_octet = 8'hd7;
            4'h2: rpat_octet = 8'h23;
            4'h3: rpat_octet = 8'h47;
            4'h4: rpat_octet = 8'h6b;
            4'h5: rpat_octet = 8'h8f;
            4'h6: rpat_octet = 8'hb3;
            4'h7: rpat_octet = 8'h14;
            4'h8: rpat_octet = 8'h5e;
            4'h9: rpat_octet = 8'hfb;
            4'ha: rpat_octet = 8'h35;
            4'hb: rpat_octet = 8'h59;
            default: rpat_octet = 8'h00;
        endcase
    endfunction : rpat_octet

endpackage : link_test_pkg

// ==== src/link_test_fifo.sv ====
`timescale 1ns/1ns
module link_test_fifo #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 16
) (
    input  wire logic             sys_clk_i,
    input  wire logic             resetn_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    output logic      [WIDTH-1:0] out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr_reg;
    logic [AW:0]      rd_ptr_reg;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    // =====================================================================
    // occupancy and handshakes
    assign count       = wr_ptr_reg - rd_ptr_reg;
    assign in_ready_o  = (count != (AW+1)'(DEPTH));
    assign out_valid_o = (count != '0);
    assign out_data_o  = mem[rd_ptr_reg[AW-1:0]];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    // storage write
    always_ff @(posedge sys_clk_i) begin
        if (push) begin
            mem[wr_ptr_reg[AW-1:0]] <= in_data_i;
        end
    end

    // pointer update
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            if (push) wr_ptr_reg <= wr_ptr_reg + (AW+1)'(1);
            if (pop)  rd_ptr_reg <= rd_ptr_reg + (AW+1)'(1);
        end
    end

endmodule : link_test_fifo

// ==== verification/rx_partner.sv ====
`timescale 1ns/1ns
module rx_partner (
    input  wire logic sys_clk_i,
    input  wire logic resetn_i,
    input  wire logic stall_i,
    input  wire logic sync_hold_i,
    output logic      lane_ready_o,
    output logic      sync_req_n_o
);
    logic [1:0] cnt_reg;

    // =========
    // receiver pacing and sync request
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            cnt_reg      <= 2'h0;
            sync_req_n_o <= 1'b1;
        end else begin
            cnt_reg      <= cnt_reg + 2'h1;
            sync_req_n_o <= !sync_hold_i;
        end
    end

    // drop ready one cycle in four while stalling
    assign lane_ready_o = !(stall_i && cnt_reg == 2'h2);
endmodule : rx_partner

// ==== verification/tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
    import link_test_pkg::*;

    logic        clk, rstn, enc, svalid, sready, lvalid, lready, sync_n, tact, stall, shold;
    logic [2:0]  mode;
    logic [4:0]  fmt;
    logic [1:0]  part;
    logic [7:0]  en, lctrl, lact;
    logic [63:0] sdata, ldata;
    int          n_mismatch = 0;
    int          check_count = 0;

    // =========
    // clock, block and receiver
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    link_test_pattern_gen DUT (
        .sys_clk_i(clk), .resetn_i(rstn), .test_mode_i(mode), .link_format_select_i(fmt),
        .part_variant_i(part), .enc_64b66b_i(enc), .lane_enable_i(en), .sync_req_n_i(sync_n),
        .sample_data_i(sdata), .sample_valid_i(svalid), .sample_ready_o(sready),
        .lane_data_o(ldata), .lane_ctrl_o(lctrl), .lane_active_o(lact),
        .lane_valid_o(lvalid), .lane_ready_i(lready), .test_active_o(tact));

    rx_partner rx (.sys_clk_i(clk), .resetn_i(rstn), .stall_i(stall), .sync_hold_i(shold),
        .lane_ready_o(lready), .sync_req_n_o(sync_n));

    // =========
    // helpers
    task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic close_out();
        if (n_mismatch == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : close_out

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick

    // restart a pattern: one normal cycle, then the mode
    task automatic set_mode(input logic [2:0] m);
        mode = 3'h0;
        tick(1);
        mode = m;
        tick(1);
    endtask : set_mode

    function automatic logic [63:0] bmask(input logic [7:0] e);
        for (int i = 0; i < 8; i++) bmask[8*i +: 8] = {8{e[i]}};
    endfunction : bmask

    function automatic logic [63:0] word(input logic [7:0] k);
        word = {8{k}} ^ 64'h0123456789abcdef;
    endfunction : word

    function automatic logic [7:0] pres(input logic [4:0] f, input logic [1:0] p);
        if (f == 5'h0e) pres = {{4{p == 2'h2}}, {2{p != 2'h0}}, 2'b11};
        else pres = {{4{p == 2'h1}}, 4'hf};
    endfunction : pres

    function automatic logic [63:0] tr_word(input int k, input logic [7:0] pr);
        logic [23:0] t;
        tr_word = 64'h0;
        for (int n = 0; n < 8; n++) begin
            t = {4'(15 - n), 4'(n), 4'h1, 4'(15 - n), 4'(n), 4'h2};
            if (pr[n]) tr_word[8*n +: 8] = t[23 - 8*k -: 8];
        end
    endfunction : tr_word

    // control flag in bit 8, octet below
    function automatic logic [8:0] ila_oct(input logic [6:0] p);
        logic c;
        c = p[4:0] == 5'h00 || p[4:0] == 5'h1f || (p[6:5] == 2'h1 && p[4:0] == 5'h01);
        if (p[4:0] == 5'h00) ila_oct = 9'h11c;
        else if (p[4:0] == 5'h1f) ila_oct = 9'h17c;
        else if (c) ila_oct = 9'h19c;
        else ila_oct = {2'b00, p};
    endfunction : ila_oct

    task automatic wait_ila();
        int k;
        for (k = 0; k < 20 && ldata[7:0] === CHAR_K285; k++) tick(1);
        if (k == 20) begin
            chk("cgs end", 64'h0, 64'h1);
            close_out();
        end
    endtask : wait_ila

    // =========
    // scenarios
    task automatic s_fill();
        int k, got;
        set_mode(MODE_K285);
        chk("k285 data", ldata, {8{CHAR_K285}});
        chk("k285 ctrl", {56'h0, lctrl}, 64'hff);
        for (k = 0; k < 16; k++) begin
            sdata = word(8'(k));
            svalid = 1'b1;
            tick(1);
        end
        svalid = 1'b0;
        chk("full ready", {63'h0, sready}, 64'h0);
        chk("k285 held", ldata, {8{CHAR_K285}});
        chk("k285 active", {63'h0, tact}, 64'h1);
        en = 8'h5a;
        stall = 1'b1;
        mode = MODE_NORMAL;
        got = 0;
        for (k = 0; k < 200 && got < 16; k++) begin
            tick(1);
            if (lvalid === 1'b1 && lready === 1'b1 && lctrl === 8'h00) begin
                chk("sample", ldata, word(8'(got)) & bmask(en));
                chk("sample lanes", {56'h0, lact}, {56'h0, en});
                got++;
            end
        end
        chk("drained", 64'(got), 64'd16);
        if (got < 16) close_out();
        chk("empty ready", {63'h0, sready}, 64'h1);
        stall = 1'b0;
        en = 8'hff;
    endtask : s_fill

    task automatic s_d215();
        en = 8'h3c;
        for (int e = 0; e < 2; e++) begin
            enc = 1'(e);
            set_mode(MODE_D215);
            chk("d215 data", ldata, {8{CHAR_D215}} & bmask(en));
            tick(3);
            chk("d215 again", ldata, {8{CHAR_D215}} & bmask(en));
            chk("d215 ctrl", {56'h0, lctrl}, 64'h0);
        end
        en = 8'hff;
    endtask : s_d215

    task automatic s_fallback();
        logic [2:0] ml [5] = '{3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
        enc = 1'b1;
        foreach (ml[i]) begin
            set_mode(ml[i]);
            tick(1);
            chk("fallback", {63'h0, tact}, 64'h0);
        end
        enc = 1'b0;
    endtask : s_fallback

    task automatic s_rpat();
        logic [7:0] rp [12] = '{8'hbe, 8'hd7, 8'h23, 8'h47, 8'h6b, 8'h8f,
                                8'hb3, 8'h14, 8'h5e, 8'hfb, 8'h35, 8'h59};
        en = 8'hf7;
        set_mode(MODE_RPAT);
        for (int k = 0; k < 24; k++) begin
            chk("rpat", ldata, {8{rp[k % 12]}} & bmask(en));
            tick(1);
        end
        en = 8'hff;
    endtask : s_rpat

    task automatic s_transport();
        logic [4:0] fl [6] = '{5'h0e, 5'h0e, 5'h0e, 5'h0f, 5'h0f, 5'h0d};
        logic [1:0] pl [6] = '{2'h0, 2'h1, 2'h2, 2'h1, 2'h2, 2'h2};
        foreach (fl[i]) begin
            fmt = fl[i];
            part = pl[i];
            set_mode(MODE_TRANSPORT);
            for (int k = 0; k < 6 && i < 5; k++) begin
                chk("transport", ldata, tr_word(k % 3, pres(fmt, part)));
                chk("lanes", {56'h0, lact}, {56'h0, pres(fmt, part)});
                tick(1);
            end
            chk("active", {63'h0, tact}, {63'h0, i < 5});
        end
    endtask : s_transport

    task automatic s_ila();
        logic [8:0] o;
        shold = 1'b1;
        set_mode(MODE_ILA_REP);
        tick(3);
        chk("cgs data", ldata, {8{CHAR_K285}});
        chk("cgs ctrl", {56'h0, lctrl}, 64'hff);
        shold = 1'b0;
        wait_ila();
        for (int p = 0; p < 160; p++) begin
            o = ila_oct(7'(p));
            chk("ila data", ldata, {8{o[7:0]}});
            chk("ila ctrl", {56'h0, lctrl}, {56'h0, {8{o[8]}}});
            tick(1);
        end
        shold = 1'b1;
        tick(3);
        chk("resync", ldata, {8{CHAR_K285}});
        shold = 1'b0;
        wait_ila();
        chk("resume", ldata, {8{CHAR_K280}});
    endtask : s_ila

    // =========
    // main sequence
    initial begin
        rstn = 1'b0;
        mode = 3'h0;
        fmt = 5'h0e;
        part = 2'h2;
        enc = 1'b0;
        en = 8'hff;
        sdata = 64'h0;
        svalid = 1'b0;
        stall = 1'b0;
        shold = 1'b0;
        tick(16);
        chk("reset ready", {63'h0, sready}, 64'h1);
        chk("reset valid", {63'h0, lvalid}, 64'h0);
        rstn = 1'b1;
        tick(1);
        s_fill();
        s_d215();
        s_fallback();
        s_rpat();
        s_transport();
        s_ila();
        close_out();
    end
endmodule : tb_top
